// file: adc_readout_pkg.sv
/*
 * constants, field layout and helpers of the six-channel readout port.
 * assumes a single 40 MHz clock shared by every block that imports it.
 */
package adc_readout_pkg;
   // ------------------------------------------------------------
   // word layout
   // ------------------------------------------------------------
   localparam int DATA_W = 12;
   localparam int TAG_W = 3;
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int RESULT_VALID_BIT = 15;
   localparam int CHANNEL_TAG_BIT2 = 14;
   localparam int CHANNEL_TAG_BIT0 = 12;
   localparam int SAMPLE_MSB = 11;
   localparam int SAMPLE_LSB = 0;
   localparam int NUM_CH = 6;
   localparam int NUM_PAIR = 3;
   localparam int FIFO_DEPTH = 16;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int CONV_TIME_NS = 1750;
   localparam int HOLD_MIN_NS = 15;
   // least times round up
   localparam int CONV_CYC = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_RAW = (HOLD_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_CYC = (HOLD_RAW < 1) ? 1 : HOLD_RAW;
   localparam int CNT_W = 7;
   // ------------------------------------------------------------
   // readout mode codes (0..5 pick one channel)
   // ------------------------------------------------------------
   localparam logic [2:0] MODE_CYCLE = 3'h6;
   localparam logic [2:0] MODE_FIFO = 3'h7;
   localparam logic [2:0] LAST_CH = 3'h5;
   localparam logic [WORD_W-1:0] EMPTY_WORD = 16'h0000;

   // assemble one output word
   function automatic logic [WORD_W-1:0] make_word(
      input logic vld,
      input logic [TAG_W-1:0] tag,
      input logic [DATA_W-1:0] smp);
      make_word = {vld, tag, smp};
   endfunction

   // channel tag of one member of a pair
   function automatic logic [TAG_W-1:0] pair_tag(
      input logic [1:0] pair,
      input logic member);
      pair_tag = {pair, member};
   endfunction
endpackage

// file: word_fifo.sv
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // storage
   logic [AW-1:0] wr_r; // write pointer
   logic [AW-1:0] rd_r; // read pointer
   logic [AW:0] cnt_r; // fill level
   wire push = in_valid_i & in_ready_o;
   wire pop = out_valid_o & out_ready_i;

   // honest flags
   assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o = mem[rd_r];

   // storage writes
   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem[wr_r] <= in_data_i;
      end
   end

   // pointers and level
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         wr_r <= wr_r + AW'(push);
         rd_r <= rd_r + AW'(pop);
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // word_fifo

// file: pair_converter.sv
/*
 * hold detection, sample capture and conversion timing of the three pairs.
 * assumes hold inputs synchronous to ref_clk_i.
 */
`timescale 1ns/1ps
module pair_converter
   import adc_readout_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // hold strobes, active low, bit 0 = pair a
   input wire logic [adc_readout_pkg::NUM_PAIR-1:0] hold_n_i,
   // front-end codes, index = channel tag
   input wire logic [adc_readout_pkg::DATA_W-1:0]
      code_i [adc_readout_pkg::NUM_CH],
   // finished pair handshake
   output logic done_valid_o,
   input wire logic done_ack_i,
   output logic [1:0] done_pair_o,
   output logic [adc_readout_pkg::DATA_W-1:0] res0_o,
   output logic [adc_readout_pkg::DATA_W-1:0] res1_o,
   // low while converting or queued
   output logic busy_n_o
);
   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DELIVER} conv_state_e;
   localparam logic [1:0] HOLD_LAST = 2'(HOLD_CYC - 1);
   localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);

   conv_state_e state_r, state_nxt;
   logic [1:0] low_cnt_r [NUM_PAIR]; // cycles hold has been low
   logic [DATA_W-1:0] samp_r [NUM_CH]; // held samples
   logic [NUM_PAIR-1:0] pend_r, pend_nxt; // queued pairs
   logic [NUM_PAIR-1:0] start; // hold accepted this cycle
   logic [NUM_PAIR-1:0] take; // queue bit taken this cycle
   logic [1:0] cur_r, cur_nxt; // pair in conversion
   logic [CNT_W-1:0] cnt_r, cnt_nxt; // conversion clock count
   wire [1:0] first_pend = pend_r[0] ? 2'h0 : (pend_r[1] ? 2'h1 : 2'h2);

   // a pair starts once its hold has been low long enough
   always_comb begin
      for (int p = 0; p < NUM_PAIR; p++) begin
         start[p] = ~hold_n_i[p] & (low_cnt_r[p] == HOLD_LAST); // R9
      end
   end

   // ------------------------------------------------------------
   // hold counters and sample capture, each pair on its own
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      for (int p = 0; p < NUM_PAIR; p++) begin
         if (reset_i | hold_n_i[p]) begin
            low_cnt_r[p] <= '0;
         end else if (low_cnt_r[p] != 2'h3) begin
            low_cnt_r[p] <= low_cnt_r[p] + 2'h1;
         end
         // both members of the pair are held together
         if (start[p] && !(state_r != ST_IDLE && cur_r == 2'(p))) begin
            samp_r[2*p] <= code_i[2*p]; // R5
            samp_r[2*p+1] <= code_i[2*p+1]; // R5
         end
      end
   end

   // ------------------------------------------------------------
   // conversion sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      cur_nxt = cur_r;
      cnt_nxt = cnt_r;
      take = '0;
      case (state_r)
         ST_IDLE: begin
            if (|pend_r) begin
               cur_nxt = first_pend;
               take[first_pend] = 1'b1;
               cnt_nxt = '0;
               state_nxt = ST_CONV;
            end
         end
         ST_CONV: begin
            cnt_nxt = cnt_r + CNT_W'(1);
            if (cnt_r == CONV_LAST) begin
               state_nxt = ST_DELIVER;
            end
         end
         ST_DELIVER: begin
            if (done_ack_i) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      // a new hold wins over taking the queue bit
      pend_nxt = (pend_r & ~take) | start;
   end

   // state registers
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_r <= ST_IDLE;
         pend_r <= '0;
         cur_r <= '0;
         cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         pend_r <= pend_nxt;
         cur_r <= cur_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // outputs
   assign done_valid_o = (state_r == ST_DELIVER);
   assign done_pair_o = cur_r;
   assign res0_o = samp_r[{cur_r, 1'b0}];
   assign res1_o = samp_r[{cur_r, 1'b1}];
   assign busy_n_o = ~(|pend_r | (state_r != ST_IDLE)); // R3

   // busy low one cycle after any accepted hold
   a_hold_busy: assert property (@(posedge ref_clk_i) // R9
      disable iff (reset_i)
      |start |=> !busy_n_o) else $error("busy not low after hold");
   // a conversion never ends within its first eight cycles
   a_conv_length: assert property (@(posedge ref_clk_i) // R3
      disable iff (reset_i)
      $rose(state_r == ST_CONV) |-> (state_r == ST_CONV)[*8])
      else $error("conversion ended early");
endmodule // pair_converter

// file: adc_readout_port.sv
/*
 * parallel readout port: result store, readout modes, byte split and
 * a sixteen-word completion fifo.
 * assumes all inputs synchronous to ref_clk_i and the pins outside
 * resolving data_o with data_oe_n_o.
 */
`timescale 1ns/1ps
// Summary of operation
// R1: top bit high when word valid
// R2: three bits below carry channel tag
// R3: busy low while conversion in progress
// R4: drive outputs only with read and select
// R5: each hold holds its own pair; a hold on a pair still converting or delivering keeps its old samples
// R6: byte mode gives two eight-bit transfers
// R7: host supplies a free-running clock
// R8: mode selects pick result or sequence
// R9: hold low one cycle starts conversion
// R10: word is valid, tag, twelve data
// R11: six result registers keep each channel
// R12: single, cycle and completion-order modes
// R13: reset clears sequencing and valid flags
module adc_readout_port
   import adc_readout_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // hold strobes, active low
   input wire logic hold_pair_a_n_i,
   input wire logic hold_pair_b_n_i,
   input wire logic hold_pair_c_n_i,
   // front-end codes per channel
   input wire logic [adc_readout_pkg::DATA_W-1:0] a0_code_i,
   input wire logic [adc_readout_pkg::DATA_W-1:0] a1_code_i,
   input wire logic [adc_readout_pkg::DATA_W-1:0] b0_code_i,
   input wire logic [adc_readout_pkg::DATA_W-1:0] b1_code_i,
   input wire logic [adc_readout_pkg::DATA_W-1:0] c0_code_i,
   input wire logic [adc_readout_pkg::DATA_W-1:0] c1_code_i,
   // read control
   input wire logic rd_n_i,
   input wire logic cs_n_i,
   input wire logic byte_mode_i,
   input wire logic readout_mode_sel2_i,
   input wire logic readout_mode_sel1_i,
   input wire logic readout_mode_sel0_i,
   // parallel data
   output logic [adc_readout_pkg::WORD_W-1:0] data_o,
   output logic data_oe_n_o,
   // status
   output logic busy_n_o,
   output logic fifo_full_o
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [DATA_W-1:0] code_w [NUM_CH]; // codes by tag
   logic [DATA_W-1:0] result_r [NUM_CH]; // stored results
   logic [NUM_CH-1:0] valid_r; // result not yet read
   logic [NUM_CH-1:0] valid_nxt;
   logic [TAG_W-1:0] cyc_ptr_r; // cycle mode pointer
   logic [TAG_W-1:0] cyc_ptr_nxt;
   logic [TAG_W-1:0] rd_ch_r; // channel of word in flight
   logic rd_act_r; // read strobe last cycle
   logic byte_ph_r; // second byte is next
   logic [WORD_W-1:0] hold_word_r; // word split over two bytes
   logic [WORD_W-1:0] data_r; // output word
   logic [WORD_W-1:0] data_nxt;
   logic push_idx_r; // member being pushed
   // converter handshake
   logic done_valid;
   logic [1:0] done_pair;
   logic [DATA_W-1:0] res0;
   logic [DATA_W-1:0] res1;
   // fifo ports
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [WORD_W-1:0] fifo_out_data;

   // ------------------------------------------------------------
   // conversion engine
   // ------------------------------------------------------------
   assign code_w[0] = a0_code_i;
   assign code_w[1] = a1_code_i;
   assign code_w[2] = b0_code_i;
   assign code_w[3] = b1_code_i;
   assign code_w[4] = c0_code_i;
   assign code_w[5] = c1_code_i;
   wire [NUM_PAIR-1:0] hold_n =
      {hold_pair_c_n_i, hold_pair_b_n_i, hold_pair_a_n_i};

   // second member pushed closes the handshake
   wire push = done_valid & fifo_in_ready;
   wire done_ack = push & push_idx_r;
   wire [TAG_W-1:0] push_tag = pair_tag(done_pair, push_idx_r);
   wire [DATA_W-1:0] push_data = push_idx_r ? res1 : res0;

   pair_converter u_conv (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .hold_n_i(hold_n),
      .code_i(code_w),
      .done_valid_o(done_valid),
      .done_ack_i(done_ack),
      .done_pair_o(done_pair),
      .res0_o(res0),
      .res1_o(res1),
      .busy_n_o(busy_n_o)
   );

   // ------------------------------------------------------------
   // read strobe decode
   // ------------------------------------------------------------
   wire [2:0] mode =
      {readout_mode_sel2_i, readout_mode_sel1_i, readout_mode_sel0_i};
   wire rd_act = ~rd_n_i & ~cs_n_i;
   wire rd_start = rd_act & ~rd_act_r;
   wire fifo_mode = (mode == MODE_FIFO); // R12
   wire cycle_mode = (mode == MODE_CYCLE); // R12
   // channel named by mode or pointer
   wire [TAG_W-1:0] sel_ch = cycle_mode ? cyc_ptr_r : mode; // R8
   wire [DATA_W-1:0] sel_data = result_r[sel_ch];
   // word ends on a plain read or the second byte
   wire word_done = rd_start & (~byte_mode_i | byte_ph_r);
   wire [TAG_W-1:0] done_ch = byte_ph_r ? rd_ch_r : sel_ch;
   // stored word selected by the mode inputs
   wire [WORD_W-1:0] reg_word =
      make_word(valid_r[sel_ch], sel_ch, sel_data); // R1 R2 R10
   wire [WORD_W-1:0] fifo_word =
      fifo_out_valid ? fifo_out_data : EMPTY_WORD; // R1
   wire [WORD_W-1:0] sel_word = fifo_mode ? fifo_word : reg_word;
   wire pop = word_done & fifo_mode & fifo_out_valid; // R12

   // ------------------------------------------------------------
   // completion fifo
   // ------------------------------------------------------------
   word_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .in_valid_i(done_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i(make_word(1'b1, push_tag, push_data)), // R10
      .out_valid_o(fifo_out_valid),
      .out_ready_i(pop),
      .out_data_o(fifo_out_data)
   );
   assign fifo_full_o = ~fifo_in_ready;

   // ------------------------------------------------------------
   // next output word and sequencing
   // ------------------------------------------------------------
   always_comb begin
      // byte mode: high byte first, then held low byte
      if (!byte_mode_i) begin
         data_nxt = sel_word;
      end else if (!byte_ph_r) begin
         data_nxt = {8'h00, sel_word[WORD_W-1:BYTE_W]}; // R6
      end else begin
         data_nxt = {8'h00, hold_word_r[BYTE_W-1:0]}; // R6
      end
      // cycle pointer walks all six channels
      cyc_ptr_nxt = cyc_ptr_r;
      if (word_done && cycle_mode) begin
         cyc_ptr_nxt = (cyc_ptr_r == LAST_CH) ? '0 : cyc_ptr_r + 3'h1;
      end
      // read clears a flag, a new result sets it; set wins
      valid_nxt = valid_r;
      if (word_done && !fifo_mode && done_ch <= LAST_CH) begin
         valid_nxt[done_ch] = 1'b0;
      end
      if (push) begin
         valid_nxt[push_tag] = 1'b1; // R11
      end
   end

   // ------------------------------------------------------------
   // result store
   // ------------------------------------------------------------
   // cleared on reset so an unconverted channel reads as zeros
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         for (int c = 0; c < NUM_CH; c++) begin
            result_r[c] <= '0; // no unknown data bits
         end
      end else if (push) begin
         result_r[push_tag] <= push_data; // R11
      end
   end

   // ------------------------------------------------------------
   // pair push order
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         push_idx_r <= 1'b0;
      end else if (push) begin
         push_idx_r <= ~push_idx_r;
      end
   end

   // ------------------------------------------------------------
   // read side registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         valid_r <= '0; // R13
         cyc_ptr_r <= '0; // R13
         byte_ph_r <= 1'b0; // R13
         rd_act_r <= 1'b0;
         rd_ch_r <= '0;
      end else begin
         valid_r <= valid_nxt;
         cyc_ptr_r <= cyc_ptr_nxt;
         rd_act_r <= rd_act;
         if (rd_start) begin
            byte_ph_r <= byte_mode_i & ~byte_ph_r; // R6
         end
         if (rd_start && !byte_ph_r) begin
            rd_ch_r <= sel_ch;
         end
      end
   end

   // output word and its held copy
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         data_r <= EMPTY_WORD;
         hold_word_r <= EMPTY_WORD;
      end else if (rd_start) begin
         data_r <= data_nxt;
         if (!byte_ph_r) begin
            hold_word_r <= sel_word;
         end
      end
   end

   // drivers on only with read and select together
   assign data_oe_n_o = ~rd_act; // R4
   assign data_o = data_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_empty_invalid: assert property (@(posedge ref_clk_i) // R1
      disable iff (reset_i)
      rd_start && !byte_mode_i && fifo_mode && !fifo_out_valid
      |=> data_o[RESULT_VALID_BIT] == 1'b0)
      else $error("empty fifo read flagged valid");
   // a read of a stored result drops its flag
   a_read_clears: assert property (@(posedge ref_clk_i) // R1
      disable iff (reset_i)
      word_done && !fifo_mode && !push && done_ch <= LAST_CH
      |=> !valid_r[$past(done_ch)])
      else $error("read left result flagged valid");
   a_single_tag: assert property (@(posedge ref_clk_i) // R2
      disable iff (reset_i)
      rd_start && !byte_mode_i && mode <= LAST_CH
      |=> data_o[CHANNEL_TAG_BIT2:CHANNEL_TAG_BIT0] == $past(mode))
      else $error("channel tag differs from selection");
   // cycle reads carry the pointer as tag
   a_cycle_tag: assert property (@(posedge ref_clk_i) // R2
      disable iff (reset_i)
      rd_start && !byte_mode_i && cycle_mode
      |=> data_o[CHANNEL_TAG_BIT2:CHANNEL_TAG_BIT0] == $past(cyc_ptr_r))
      else $error("cycle read tag differs from pointer");
   // results waiting for the fifo keep busy low
   a_busy_deliver: assert property (@(posedge ref_clk_i) // R3
      disable iff (reset_i)
      done_valid |-> !busy_n_o)
      else $error("busy high with results pending");
   a_drive_gate: assert property (@(posedge ref_clk_i) // R4
      disable iff (reset_i)
      (rd_n_i || cs_n_i) |-> data_oe_n_o)
      else $error("outputs driven without read and select");
   // drivers on whenever read and select are both low
   a_drive_on_read: assert property (@(posedge ref_clk_i) // R4
      disable iff (reset_i)
      (!rd_n_i && !cs_n_i) |-> !data_oe_n_o)
      else $error("outputs not driven during read");
   a_byte_split: assert property (@(posedge ref_clk_i) // R6
      disable iff (reset_i)
      rd_start && byte_mode_i && !byte_ph_r
      |=> byte_ph_r && data_o[WORD_W-1:BYTE_W] == 8'h00)
      else $error("byte transfer malformed");
   // second byte is the held low half
   a_low_byte: assert property (@(posedge ref_clk_i) // R6
      disable iff (reset_i)
      rd_start && byte_mode_i && byte_ph_r
      |=> !byte_ph_r && data_o == {8'h00, $past(hold_word_r[BYTE_W-1:0])})
      else $error("second byte malformed");
   a_single_data: assert property (@(posedge ref_clk_i) // R10
      disable iff (reset_i)
      rd_start && !byte_mode_i && mode <= LAST_CH && !push
      |=> data_o[SAMPLE_MSB:SAMPLE_LSB] == $past(sel_data))
      else $error("data bits differ from stored result");
   a_store_result: assert property (@(posedge ref_clk_i) // R11
      disable iff (reset_i)
      push |=> valid_r[$past(push_tag)])
      else $error("stored result not flagged valid");
   a_fifo_order: assert property (@(posedge ref_clk_i) // R12
      disable iff (reset_i)
      pop && !byte_mode_i |=> data_o == $past(fifo_out_data))
      else $error("fifo word out of order");
   a_cycle_wrap: assert property (@(posedge ref_clk_i) // R12
      disable iff (reset_i)
      word_done && cycle_mode && cyc_ptr_r == LAST_CH |=> cyc_ptr_r == '0)
      else $error("cycle pointer failed to wrap");
   a_reset_clear: assert property (@(posedge ref_clk_i) // R13
      reset_i |=> valid_r == '0 && cyc_ptr_r == '0 && !byte_ph_r)
      else $error("reset left stale state");
endmodule // adc_readout_port

// file: host_model.sv
/*
 * host side of the readout port: hold strobes and read cycles.
 * assumes a free-running ref_clk_i; moves pins 2 ns after a rise.
 */
`timescale 1ns/1ps
module host_model (
   // clock
   input wire logic ref_clk_i,
   // device outputs
   input wire logic [15:0] data_i,
   input wire logic data_oe_n_i,
   // control to the device
   output logic [2:0] hold_n_o,
   output logic rd_n_o,
   output logic cs_n_o,
   output logic [2:0] mode_o
);
   // ------------------------------------------------------------
   // idle levels at time zero
   // ------------------------------------------------------------
   initial begin
      hold_n_o = 3'h7;
      rd_n_o = 1'b1;
      cs_n_o = 1'b1;
      mode_o = 3'h0;
   end

   // one clock low (25 ns) on the chosen pairs
   task automatic hold(input logic [2:0] m);
      hold_n_o = ~m;
      @(posedge ref_clk_i);
      #2 hold_n_o = 3'h7;
   endtask

   // one read, mode set with the strobes, released two clocks after
   task automatic rd(input logic [2:0] m, input logic sel,
      output logic [15:0] w, output logic oe_n);
      mode_o = m;
      rd_n_o = 1'b0;
      cs_n_o = ~sel;
      @(posedge ref_clk_i);
      #2 oe_n = data_oe_n_i;
      @(posedge ref_clk_i);
      #2 w = data_i;
      rd_n_o = 1'b1;
      cs_n_o = 1'b1;
      @(posedge ref_clk_i);
      #2;
   endtask
endmodule // host_model

// file: tb.sv
/*
 * self-checking bench of the readout port.
 * assumes host_model drives holds, strobes and mode pins.
 */
`timescale 1ns/1ps
module tb;
   import adc_readout_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic ref_clk_i;
   logic reset_i;
   logic byte_mode; // split transfers
   logic [2:0] hold_n;
   logic [2:0] mode;
   logic rd_n;
   logic cs_n;
   logic [DATA_W-1:0] code [NUM_CH]; // front-end codes
   logic [DATA_W-1:0] stored [NUM_CH]; // expected results
   logic [15:0] q [$]; // expected completion order
   logic [15:0] data;
   logic [15:0] w;
   logic [15:0] e;
   logic oe_n;
   logic oe_seen; // enable level seen during a read
   logic busy_n;
   logic full;
   int err_total;
   int cmp_count;

   // free-running 40 MHz clock
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end

   adc_readout_port dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .hold_pair_a_n_i(hold_n[0]), .hold_pair_b_n_i(hold_n[1]),
      .hold_pair_c_n_i(hold_n[2]), .a0_code_i(code[0]),
      .a1_code_i(code[1]), .b0_code_i(code[2]), .b1_code_i(code[3]),
      .c0_code_i(code[4]), .c1_code_i(code[5]), .rd_n_i(rd_n),
      .cs_n_i(cs_n), .byte_mode_i(byte_mode),
      .readout_mode_sel2_i(mode[2]), .readout_mode_sel1_i(mode[1]),
      .readout_mode_sel0_i(mode[0]), .data_o(data),
      .data_oe_n_o(oe_n), .busy_n_o(busy_n), .fifo_full_o(full));

   host_model host (.ref_clk_i(ref_clk_i), .data_i(data),
      .data_oe_n_i(oe_n), .hold_n_o(hold_n), .rd_n_o(rd_n),
      .cs_n_o(cs_n), .mode_o(mode));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // compare and count
   task automatic chk(input logic [15:0] s, input logic [15:0] x);
      cmp_count++;
      if (s !== x) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, x);
      end
   endtask

   // verdict and end of run
   task automatic test_done();
      $display("comparisons %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // selected read, masked compare
   task automatic rdm(input logic [2:0] m, input logic [15:0] x,
      input logic [15:0] msk);
      host.rd(m, 1'b1, w, oe_seen);
      chk({15'h0, oe_seen}, 16'h0);
      chk(w & msk, x);
   endtask

   // bounded wait for idle
   task automatic wait_idle(input int lim);
      int n;
      n = 0;
      while (busy_n !== 1'b1 && n < lim) begin
         @(posedge ref_clk_i);
         #2 n++;
      end
      if (busy_n !== 1'b1) begin
         err_total++;
         test_done();
      end
   endtask

   // note expectations, start pairs, then move the codes
   task automatic start(input logic [2:0] m);
      for (int p = 0; p < 3; p++)
         if (m[p]) begin
            for (int k = 2 * p; k < 2 * p + 2; k++) begin
               stored[k] = code[k];
               q.push_back({1'b1, 3'(k), code[k]});
            end
         end
      host.hold(m);
      @(posedge ref_clk_i);
      #2 chk({15'h0, busy_n}, 16'h0);
      for (int k = 0; k < NUM_CH; k++)
         code[k] = code[k] + 12'h111;
      repeat (60) @(posedge ref_clk_i);
      #2 chk({15'h0, busy_n}, 16'h0);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      reset_i = 1'b1;
      byte_mode = 1'b0;
      err_total = 0;
      cmp_count = 0;
      for (int i = 0; i < NUM_CH; i++)
         code[i] = 12'(32'h123 + i * 32'h2a1);
      repeat (5) @(posedge ref_clk_i);
      #2 reset_i = 1'b0;
      // state after reset
      chk({14'h0, busy_n, full}, 16'h2);
      rdm(3'h0, 16'h0000, 16'hf000);
      rdm(MODE_FIFO, EMPTY_WORD, 16'hffff);
      // strobe without select keeps the bus off
      host.rd(3'h0, 1'b0, w, oe_seen);
      chk({15'h0, oe_seen}, 16'h1);
      // one pair, single-channel reads, valid cleared by reading
      start(3'h1);
      wait_idle(100);
      for (int t = 0; t < 2; t++)
         rdm(3'(t), {1'b1, 3'(t), stored[t]}, 16'hffff);
      rdm(3'h0, 16'h0000, 16'hf000);
      // all pairs at once, cycle mode walks every channel
      start(3'h7);
      wait_idle(300);
      for (int t = 0; t < NUM_CH; t++)
         rdm(MODE_CYCLE, {1'b1, 3'(t), stored[t]}, 16'hffff);
      for (int t = 0; t < NUM_CH; t++)
         rdm(3'(t), {1'b0, 3'(t), 12'h0}, 16'hf000);
      // one pair leaves the others untouched
      start(3'h2);
      wait_idle(100);
      rdm(3'h0, 16'h0000, 16'hf000);
      rdm(3'h2, {1'b1, 3'h2, stored[2]}, 16'hffff);
      rdm(3'h4, 16'h4000, 16'hf000);
      // fill the fifo to sixteen, then stall a further pair
      start(3'h4);
      wait_idle(100);
      start(3'h1);
      wait_idle(100);
      start(3'h2);
      wait_idle(100);
      chk({15'h0, full}, 16'h1);
      start(3'h4);
      repeat (100) @(posedge ref_clk_i);
      #2 chk({15'h0, busy_n}, 16'h0);
      // drain in completion order, stalled pair follows
      while (q.size() > 0)
         rdm(MODE_FIFO, q.pop_front(), 16'hffff);
      rdm(MODE_FIFO, EMPTY_WORD, 16'hffff);
      chk({14'h0, busy_n, full}, 16'h2);
      // byte mode: high half then low half of one word
      e = {1'b1, 3'h4, stored[4]};
      byte_mode = 1'b1;
      rdm(3'h4, {8'h00, e[15:8]}, 16'hffff);
      rdm(3'h4, {8'h00, e[7:0]}, 16'hffff);
      byte_mode = 1'b0;
      rdm(3'h4, 16'h4000, 16'hf000);
      // reset in mid-conversion
      host.hold(3'h1);
      repeat (10) @(posedge ref_clk_i);
      #2 reset_i = 1'b1;
      repeat (2) @(posedge ref_clk_i);
      #2 reset_i = 1'b0;
      chk({14'h0, busy_n, full}, 16'h2);
      rdm(MODE_CYCLE, 16'h0000, 16'hf000);
      rdm(MODE_FIFO, EMPTY_WORD, 16'hffff);
      test_done();
   end
endmodule // tb
